// ===== dv/testbench.sv
// self-checking bench of the alternate-mode mux
`timescale 1ns/1ps
`include "uam_regs.vh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [31:0] dat_i = 32'h0;
  logic        rst_pin_n = 1'b1;
  logic        rxcmd_ack_i = 1'b0;
  logic        exit_req = 1'b0;
  logic        id_gnd_n = 1'b1;
  logic [3:0]  stp_hold = 4'h0;
  logic [3:0]  id_code = 4'h0;
  logic [5:0]  ana = 6'h00;
  logic [6:0]  irq_src = 7'h00;
  logic [7:0]  lk_d = 8'h00;
  logic [7:0]  lk_oe = 8'h00;
  logic [31:0] seed = 32'h0f9e;
  logic [31:0] exp_q[$];
  int          n_fail = 0;
  int          check_count = 0;
  wire         ack_o, stp_i, dir_o, clk_run_o, rxcmd_valid_o, usb_tx_enable_o, usb_tx_data_o;
  wire         serial_single_ended_zero_drive_o, uart_minus_drive_o, uart_minus_oe_o;
  wire         pull_up_125k_o, regulator_uart_o, low_speed_edge_o, left_audio_switch_enable_o;
  wire         right_audio_switch_enable_o, id_ground_drive_o, id_pull_up_330k_enable_o;
  wire         id_pull_up_100k_enable_o;
  wire [1:0]   regulator_setting_o;
  wire [7:0]   data_i, data_o, data_oe_o, rxcmd_o;
  wire [31:0]  dat_o;
  uam_alt_mux i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h1), .dat_i,
    .dat_o, .ack_o, .active_low_reset_pin_i(rst_pin_n), .stp_i, .data_i, .data_o, .data_oe_o,
    .dir_o, .clk_run_o, .rxcmd_valid_o, .rxcmd_o, .rxcmd_ack_i, .receive_plus_line_i(ana[0]),
    .receive_minus_line_i(ana[1]), .receive_diff_i(ana[2]), .session_valid_i(ana[3]),
    .bus_power_valid_i(ana[4]), .id_grounded_comparator_i(id_gnd_n), .id_floating_i(ana[5]),
    .irq_src_i(irq_src), .id_code_i(id_code), .usb_tx_enable_o, .usb_tx_data_o,
    .serial_single_ended_zero_drive_o, .uart_minus_drive_o, .uart_minus_oe_o, .pull_up_125k_o,
    .regulator_uart_o, .regulator_setting_o, .low_speed_edge_o, .left_audio_switch_enable_o,
    .right_audio_switch_enable_o, .id_ground_drive_o, .id_pull_up_330k_enable_o,
    .id_pull_up_100k_enable_o);
  uam_link_model i_link (.clk_i, .dir_i(dir_o), .exit_req_i(exit_req), .stp_hold_i(stp_hold),
    .drive_i(lk_d), .drive_oe_i(lk_oe), .dev_data_i(data_o), .dev_oe_i(data_oe_o),
    .stp_o(stp_i), .bus_o(data_i));
  initial forever #12.5 clk_i = ~clk_i;
  // ==========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask
  task automatic wait_on(input int sel, input logic v);
    int n = 0;
    while ((sel == 0 ? dir_o : sel == 1 ? stp_i : rxcmd_valid_o) !== v && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk(n < 60, "wait timed out");
  endtask
  // new random analog levels and link drive; pull-up kept on for id-floating
  task automatic shake();
    seed = xs(seed);
    ana  <= seed[5:0];
    lk_d <= seed[15:8] | 8'h80;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic leave();
    seed = xs(seed);
    stp_hold <= seed[3:0];
    exit_req <= 1'b1;
    wait_on(0, 1'b0);
    exit_req <= 1'b0;
    lk_oe    <= 8'h00;
    wait_on(1, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(data_oe_o === 8'h00, "pins not restored");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // read data compared against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc_i && !we_i)
      chk(dat_o === exp_q.pop_front(), "read data");
  end
  initial begin
    #(25ns * 20000);
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    finish_test();
  end
  // ==========
  // scenarios
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`UAM_ADR_FUNC, `UAM_FUNC_RST);
    wb(1'b1, `UAM_ADR_STAT, 8'hff);
    rd(`UAM_ADR_STAT, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `UAM_ADR_FUNC, 8'(i));
      rd(`UAM_ADR_FUNC, 8'(i));
    end
    $display("test registers done");
    wb(1'b1, `UAM_ADR_MASK, 8'h7f);
    wb(1'b1, `UAM_ADR_IFC, 8'h01);
    wait_on(0, 1'b1);
    lk_oe <= 8'h07;
    shake();
    chk(clk_run_o === 1'b0, "clock not stopped");
    chk(data_oe_o === 8'hf8 && data_o[7:3] === {1'b0, ana[2:0], 1'b0}, "serial rx");
    chk(usb_tx_enable_o === lk_d[0] && (!lk_d[0]
      || {serial_single_ended_zero_drive_o, usb_tx_data_o} === lk_d[2:1]), "serial tx");
    irq_src <= 7'h04;
    repeat (3) @(posedge clk_i);
    chk(data_o[3] === 1'b1, "irq not raised");
    irq_src <= 7'h00;
    repeat (3) @(posedge clk_i);
    chk(data_o[3] === 1'b0, "irq not level");
    leave();
    rd(`UAM_ADR_IFC, 8'h00);
    $display("test serial done");
    wb(1'b1, `UAM_ADR_FUNC, {6'h0, `UAM_XS_LS});
    wb(1'b1, `UAM_ADR_IOPWR, 8'h02);
    wb(1'b1, `UAM_ADR_CARKIT, 8'h0f);
    chk(left_audio_switch_enable_o === 1'b1 && right_audio_switch_enable_o === 1'b1, "sw");
    wb(1'b1, `UAM_ADR_IFC, 8'h0c);
    wait_on(0, 1'b1);
    lk_oe <= 8'h01;
    shake();
    chk(clk_run_o === 1'b1 && data_oe_o === 8'hfe, "carkit clock or pins");
    chk(data_o[1] === ana[0] && uart_minus_drive_o === lk_d[0] && uart_minus_oe_o, "uart");
    chk(pull_up_125k_o && regulator_uart_o && regulator_setting_o === 2'h2, "uart pwr");
    chk(low_speed_edge_o === 1'b1, "edge rate");
    id_gnd_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(data_o[3] === 1'b1, "id irq missing");
    id_gnd_n <= 1'b1;
    leave();
    rd(`UAM_ADR_IFC, 8'h08);
    $display("test carkit done");
    wb(1'b1, `UAM_ADR_IFC, 8'h00);
    wb(1'b1, `UAM_ADR_MASK, 8'h01);
    wb(1'b1, `UAM_ADR_HSET, 8'h01);
    wait_on(0, 1'b1);
    lk_oe <= 8'hc4;
    shake();
    chk(data_oe_o === 8'h3b && data_o[5:3] === {ana[5], id_gnd_n, 1'b0}, "headset id");
    chk(data_o[1:0] === ana[4:3] && left_audio_switch_enable_o === 1'b1, "headset vbus");
    chk({id_pull_up_100k_enable_o, id_pull_up_330k_enable_o, id_ground_drive_o}
      === {lk_d[7:6], lk_d[2]}, "headset link pins");
    leave();
    $display("test headset done");
    wb(1'b1, `UAM_ADR_IFC, 8'h01);
    wait_on(0, 1'b1);
    rst_pin_n <= 1'b0;
    @(posedge clk_i);
    rst_pin_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(dir_o === 1'b0 && data_oe_o === 8'h00, "reset pin");
    rd(`UAM_ADR_IFC, 8'h00);
    $display("test reset pin done");
    seed = xs(seed);
    id_code <= seed[3:0];
    wb(1'b1, `UAM_ADR_IDCONV, 8'h03);
    wait_on(2, 1'b1);
    chk(rxcmd_o[7] === 1'b1, "conversion rxcmd");
    rxcmd_ack_i <= 1'b1;
    @(posedge clk_i);
    rxcmd_ack_i <= 1'b0;
    rd(`UAM_ADR_IDCONV, {id_code, 4'h2});
    id_gnd_n <= 1'b0;
    wait_on(2, 1'b1);
    chk(rxcmd_o[6] === 1'b0, "id ground rxcmd");
    $display("test id measure done");
    finish_test();
  end
endmodule // testbench

// ===== dv/uam_alt_mux_properties.sv
// port-level checker of the alternate-mode mux
`timescale 1ns/1ps
module uam_alt_mux_props (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       active_low_reset_pin_i,
  input wire logic       stp_i,
  input wire logic [7:0] data_o,
  input wire logic [7:0] data_oe_o,
  input wire logic       dir_o,
  input wire logic       clk_run_o,
  input wire logic       rxcmd_valid_o,
  input wire logic       receive_plus_line_i,
  input wire logic       receive_minus_line_i,
  input wire logic       receive_diff_i,
  input wire logic       session_valid_i,
  input wire logic       id_grounded_comparator_i,
  input wire logic       id_floating_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // bus and mode sequencing
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer is not a single pulse");
  a_dir_held: assert property (dir_o && !stp_i && active_low_reset_pin_i |=> dir_o)
    else $error("dir dropped without stop");
  a_dir_exit: assert property (dir_o && stp_i |-> ##[1:2] !dir_o)
    else $error("dir not dropped after stop");
  a_dir_wait: assert property (!dir_o && stp_i |=> !dir_o)
    else $error("dir raised while stop still high");
  a_clk_sync: assert property (!dir_o |-> clk_run_o)
    else $error("clock stopped outside alternate mode");
  a_remap_after: assert property ($rose(dir_o) |=> data_oe_o != 8'h00)
    else $error("pins not remapped after dir");
  a_pins_back: assert property ($fell(dir_o) |=> data_oe_o == 8'h00)
    else $error("pins still driven after exit");
  a_pin_reset: assert property (!active_low_reset_pin_i |=> !dir_o && data_oe_o == 8'h00)
    else $error("reset pin did not restore sync mode");
  // ==========
  // pin maps
  a_serial_rx: assert property (data_oe_o == 8'hf8 |-> !data_o[7]
    && data_o[6:4] == {$past(receive_diff_i), $past(receive_minus_line_i),
    $past(receive_plus_line_i)}) else $error("serial receive pins wrong");
  a_carkit_low: assert property (data_oe_o == 8'hfe |-> data_o[7:4] == 4'h0 && !data_o[2])
    else $error("carkit reserved pins not low");
  a_headset_out: assert property (data_oe_o == 8'h3b |-> !data_o[3]
    && data_o[0] == $past(session_valid_i) && data_o[4] == $past(id_grounded_comparator_i)
    && data_o[5] == $past(id_floating_i)) else $error("headset outputs wrong");
  c_serial: cover property (data_oe_o == 8'hf8);
  c_carkit: cover property (data_oe_o == 8'hfe);
  c_headset: cover property (data_oe_o == 8'h3b);
  c_rxcmd: cover property (rxcmd_valid_o);
endmodule // uam_alt_mux_props

bind uam_alt_mux uam_alt_mux_props i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .active_low_reset_pin_i, .stp_i, .data_o, .data_oe_o, .dir_o, .clk_run_o, .rxcmd_valid_o,
  .receive_plus_line_i, .receive_minus_line_i, .receive_diff_i, .session_valid_i,
  .id_grounded_comparator_i, .id_floating_i);

// ===== dv/uam_link_model.sv
// link-side model: stop line and the link-owned data pins
`timescale 1ns/1ps
module uam_link_model (
  input  wire logic       clk_i,
  input  wire logic       dir_i,
  input  wire logic       exit_req_i,
  input  wire logic [3:0] stp_hold_i,
  input  wire logic [7:0] drive_i,
  input  wire logic [7:0] drive_oe_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic [7:0] dev_oe_i,
  output logic            stp_o,
  output logic [7:0]      bus_o
);
  logic [3:0] low_cnt_q = 4'h0;
  initial stp_o = 1'b0;
  // undriven bits fall to the weak pull-downs
  assign bus_o = (dev_oe_i & dev_data_i) | (~dev_oe_i & drive_oe_i & drive_i);
  // stop held a variable time after dir drops, to test slow links
  always @(posedge clk_i) begin
    if (exit_req_i && dir_i) begin
      stp_o <= 1'b1;
    end else if (stp_o && !dir_i) begin
      low_cnt_q <= low_cnt_q + 4'h1;
      if (low_cnt_q == stp_hold_i) begin
        stp_o     <= 1'b0;
        low_cnt_q <= 4'h0;
      end
    end
  end
endmodule // uam_link_model

// ===== hw/uam_alt_mux.v
// alternate-mode pin mux, mode sequencer and register slave
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "uam_regs.vh"
module uam_alt_mux #(
  parameter N_SRC = 7,
  parameter RES_W = 4,
  parameter CONV  = `UAM_CONV_CYC
) (
  input  wire             clk_i,
  input  wire             rst_i,
  // wishbone classic slave
  input  wire             cyc_i,
  input  wire             stb_i,
  input  wire             we_i,
  input  wire [4:0]       adr_i,
  input  wire [3:0]       sel_i,
  input  wire [31:0]      dat_i,
  output reg  [31:0]      dat_o,
  output wire             ack_o,
  // ulpi side
  input  wire             active_low_reset_pin_i,
  input  wire             stp_i,
  input  wire [7:0]       data_i,
  output reg  [7:0]       data_o,
  output reg  [7:0]       data_oe_o,
  output reg              dir_o,
  output wire             clk_run_o,
  output reg              rxcmd_valid_o,
  output reg  [7:0]       rxcmd_o,
  input  wire             rxcmd_ack_i,
  // analog front end
  input  wire             receive_plus_line_i,
  input  wire             receive_minus_line_i,
  input  wire             receive_diff_i,
  input  wire             session_valid_i,
  input  wire             bus_power_valid_i,
  input  wire             id_grounded_comparator_i,
  input  wire             id_floating_i,
  input  wire [N_SRC-1:0] irq_src_i,
  input  wire [RES_W-1:0] id_code_i,
  output reg              usb_tx_enable_o,
  output reg              usb_tx_data_o,
  output reg              serial_single_ended_zero_drive_o,
  output reg              uart_minus_drive_o,
  output reg              uart_minus_oe_o,
  output reg              pull_up_125k_o,
  output reg              regulator_uart_o,
  output reg  [1:0]       regulator_setting_o,
  output reg              low_speed_edge_o,
  output wire             left_audio_switch_enable_o,
  output wire             right_audio_switch_enable_o,
  output reg              id_ground_drive_o,
  output reg              id_pull_up_330k_enable_o,
  output reg              id_pull_up_100k_enable_o
);
  localparam [4:0] ST_SYNC  = 5'h01;
  localparam [4:0] ST_ENTER = 5'h02;
  localparam [4:0] ST_ALT   = 5'h04;
  localparam [4:0] ST_EXIT  = 5'h08;
  localparam [4:0] ST_WAIT  = 5'h10;
  localparam [2:0] M_SER6   = 3'h1;
  localparam [2:0] M_CAR    = 3'h2;
  localparam [2:0] M_HSET   = 3'h4;

  // reset pin acts like the system reset
  wire        srst = rst_i | ~active_low_reset_pin_i;
  reg         ack_q;
  reg         ser6_q;
  reg         car_accessory_mode_select_q;
  reg         clock_keep_running_q;
  reg  [1:0]  transceiver_speed_select_q;
  reg         uart_transmit_enable_q;
  reg         uart_receive_enable_q;
  reg         left_audio_switch_enable_q;
  reg         right_audio_switch_enable_q;
  reg         hset_q;
  reg         id_measure_irq_enable_q;
  reg  [1:0]  uart_regulator_setting_q;
  reg  [7:0]  mask_q;
  reg  [4:0]  state_q;
  reg  [4:0]  state_d;
  reg  [2:0]  mode_q;
  reg         keep_q;
  reg         idg_q;
  reg         rx_alt_q;
  reg         rx_id_q;

  wire        req    = cyc_i & stb_i & ~ack_q;
  wire        wr     = req & we_i & sel_i[0];
  wire [7:0]  wd     = dat_i[7:0];
  wire        in_alt = state_q == ST_ALT;
  wire        uart   = mode_q[1] & (uart_transmit_enable_q | uart_receive_enable_q);
  wire        irq;
  wire        id_busy;
  wire        id_done;
  wire [RES_W-1:0] id_res;
  wire        start_w = wr && adr_i == `UAM_ADR_IDCONV && wd[`UAM_ID_START];
  wire        entry   = ser6_q | car_accessory_mode_select_q | hset_q;
  // id-grounded is always armed as a source outside synchronous mode
  wire [N_SRC:0] src  = {id_grounded_comparator_i, irq_src_i};
  wire [N_SRC:0] msk  = {1'b1, mask_q[N_SRC-1:0]};

  // =====================================================================
  // helpers
  uam_irq_sampler #(
    .N        (N_SRC + 1)
  ) u_irq (
    .clk_i    (clk_i),
    .rst_i    (srst),
    // baseline tracks until alt mode, so status never shows a stale compare
    .sample_i (!in_alt),
    .src_i    (src),
    .mask_i   (msk),
    .irq_o    (irq)
  );

  uam_id_measure #(
    .W        (RES_W),
    .CONV     (CONV)
  ) u_idm (
    .clk_i    (clk_i),
    .rst_i    (srst),
    .start_i  (start_w),
    .code_i   (id_code_i),
    .busy_o   (id_busy),
    .done_o   (id_done),
    .result_o (id_res)
  );

  // =====================================================================
  // wishbone ack: one wait-free cycle after the request is seen
  always @(posedge clk_i) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign ack_o = ack_q;

  // =====================================================================
  // registers
  always @(posedge clk_i) begin
    if (srst) begin
      ser6_q                      <= 1'b0;
      car_accessory_mode_select_q <= 1'b0;
      clock_keep_running_q        <= 1'b0;
      transceiver_speed_select_q  <= `UAM_FUNC_RST;
      uart_transmit_enable_q      <= 1'b0;
      uart_receive_enable_q       <= 1'b0;
      left_audio_switch_enable_q  <= 1'b0;
      right_audio_switch_enable_q <= 1'b0;
      hset_q                      <= 1'b0;
      id_measure_irq_enable_q     <= 1'b0;
      uart_regulator_setting_q    <= 2'h0;
      mask_q                      <= `UAM_MASK_RST;
    end else begin
      if (state_q == ST_WAIT && !stp_i) begin
        ser6_q                      <= 1'b0;
        car_accessory_mode_select_q <= 1'b0;
        hset_q                      <= 1'b0;
      end
      if (wr) begin
        case (adr_i)
          `UAM_ADR_IFC: begin
            ser6_q                      <= wd[`UAM_IFC_SER6];
            car_accessory_mode_select_q <= wd[`UAM_IFC_CAR];
            clock_keep_running_q        <= wd[`UAM_IFC_KEEP];
          end
          `UAM_ADR_FUNC: begin
            transceiver_speed_select_q <= wd[1:0];
          end
          `UAM_ADR_CARKIT: begin
            uart_transmit_enable_q      <= wd[`UAM_CK_TXEN];
            uart_receive_enable_q       <= wd[`UAM_CK_RXEN];
            left_audio_switch_enable_q  <= wd[`UAM_CK_LEFT];
            right_audio_switch_enable_q <= wd[`UAM_CK_RIGHT];
          end
          `UAM_ADR_HSET: begin
            hset_q <= wd[0];
          end
          `UAM_ADR_IDCONV: begin
            id_measure_irq_enable_q <= wd[`UAM_ID_IRQEN];
          end
          `UAM_ADR_IOPWR: begin
            uart_regulator_setting_q <= wd[1:0];
          end
          `UAM_ADR_MASK: begin
            mask_q <= wd;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // switches act straight from the register, no mode dependence
  assign left_audio_switch_enable_o  = left_audio_switch_enable_q;
  assign right_audio_switch_enable_o = right_audio_switch_enable_q;

  // =====================================================================
  // read data
  always @(posedge clk_i) begin
    if (srst) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= 32'h0000_0000;
      case (adr_i)
        `UAM_ADR_IFC: begin
          dat_o[`UAM_IFC_SER6] <= ser6_q;
          dat_o[`UAM_IFC_CAR]  <= car_accessory_mode_select_q;
          dat_o[`UAM_IFC_KEEP] <= clock_keep_running_q;
        end
        `UAM_ADR_FUNC: begin
          dat_o[1:0] <= transceiver_speed_select_q;
        end
        `UAM_ADR_CARKIT: begin
          dat_o[3:0] <= {right_audio_switch_enable_q, left_audio_switch_enable_q,
                         uart_receive_enable_q, uart_transmit_enable_q};
        end
        `UAM_ADR_HSET: begin
          dat_o[0] <= hset_q;
        end
        `UAM_ADR_IDCONV: begin
          dat_o[`UAM_ID_START] <= id_busy;
          dat_o[`UAM_ID_IRQEN] <= id_measure_irq_enable_q;
          dat_o[`UAM_ID_RES_LSB +: RES_W] <= id_res;
        end
        `UAM_ADR_IOPWR: begin
          dat_o[1:0] <= uart_regulator_setting_q;
        end
        `UAM_ADR_MASK: begin
          dat_o[7:0] <= mask_q;
        end
        `UAM_ADR_STAT: begin
          dat_o[7:0] <= {2'h0, irq, clk_run_o, mode_q, dir_o};
        end
        default: begin
        end
      endcase
    end
  end

  // =====================================================================
  // mode sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SYNC: begin
        if (entry && !req) begin
          state_d = ST_ENTER;
        end
      end
      ST_ENTER: begin
        state_d = ST_ALT;
      end
      ST_ALT: begin
        if (stp_i) begin
          state_d = ST_EXIT;
        end
      end
      ST_EXIT: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (!stp_i) begin
          state_d = ST_SYNC;
        end
      end
      default: begin
        state_d = ST_SYNC;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (srst) begin
      state_q <= ST_SYNC;
      mode_q  <= 3'h0;
      keep_q  <= 1'b0;
      dir_o   <= 1'b0;
    end else begin
      state_q <= state_d;
      // dir rises only after the baseline sample, holds until stp
      dir_o   <= state_d == ST_ALT;
      if (state_q == ST_SYNC && state_d == ST_ENTER) begin
        keep_q <= clock_keep_running_q;
        if (ser6_q) begin
          mode_q <= M_SER6;
        end else if (car_accessory_mode_select_q) begin
          mode_q <= M_CAR;
        end else begin
          mode_q <= M_HSET;
        end
      end else if (state_q == ST_EXIT) begin
        mode_q <= 3'h0;
      end
    end
  end

  // clock only stops while the alternate mode is really active
  assign clk_run_o = ~in_alt | keep_q;

  // =====================================================================
  // pin mux; outside ALT every alternate function except regulator_setting_o and the audio switches is released
  always @(posedge clk_i) begin
    if (srst) begin
      data_o                           <= 8'h00;
      data_oe_o                        <= 8'h00;
      usb_tx_enable_o                  <= 1'b0;
      usb_tx_data_o                    <= 1'b0;
      serial_single_ended_zero_drive_o <= 1'b0;
      uart_minus_drive_o               <= 1'b0;
      uart_minus_oe_o                  <= 1'b0;
      pull_up_125k_o                   <= 1'b0;
      regulator_uart_o                 <= 1'b0;
      regulator_setting_o              <= 2'h0;
      low_speed_edge_o                 <= 1'b0;
      id_ground_drive_o                <= 1'b0;
      id_pull_up_330k_enable_o         <= 1'b0;
      id_pull_up_100k_enable_o         <= 1'b0;
    end else begin
      data_o                           <= 8'h00;
      data_oe_o                        <= 8'h00;
      usb_tx_enable_o                  <= 1'b0;
      usb_tx_data_o                    <= 1'b0;
      serial_single_ended_zero_drive_o <= 1'b0;
      uart_minus_drive_o               <= 1'b0;
      uart_minus_oe_o                  <= 1'b0;
      pull_up_125k_o                   <= 1'b0;
      regulator_uart_o                 <= 1'b0;
      regulator_setting_o              <= uart_regulator_setting_q;
      low_speed_edge_o                 <= 1'b0;
      id_ground_drive_o                <= 1'b0;
      id_pull_up_330k_enable_o         <= 1'b0;
      id_pull_up_100k_enable_o         <= 1'b0;
      if (in_alt && mode_q == M_SER6) begin
        usb_tx_enable_o                  <= data_i[0];
        usb_tx_data_o                    <= data_i[0] & data_i[1];
        serial_single_ended_zero_drive_o <= data_i[0] & data_i[2];
        data_oe_o <= 8'hf8;
        data_o    <= {1'b0, receive_diff_i, receive_minus_line_i,
                      receive_plus_line_i, irq, 3'h0};
      end
      if (in_alt && mode_q == M_CAR) begin
        // no line-state path here by design
        data_oe_o <= 8'hfe;
        data_o    <= {4'h0, irq, 1'b0,
                      uart_receive_enable_q & receive_plus_line_i,
                      1'b0};
        uart_minus_drive_o <= data_i[0];
        uart_minus_oe_o    <= uart_transmit_enable_q;
        pull_up_125k_o     <= uart;
        regulator_uart_o   <= uart;
        low_speed_edge_o   <= uart &&
                              transceiver_speed_select_q == `UAM_XS_LS;
      end
      if (in_alt && mode_q == M_HSET) begin
        data_oe_o <= 8'h3b;
        data_o    <= {2'h0, id_floating_i, id_grounded_comparator_i, 1'b0, 1'b0,
                      bus_power_valid_i & mask_q[`UAM_SRC_VBUS],
                      session_valid_i};
        id_ground_drive_o        <= data_i[2];
        id_pull_up_330k_enable_o <= data_i[6];
        id_pull_up_100k_enable_o <= data_i[7];
      end
    end
  end

  // =====================================================================
  // rxcmd events in synchronous mode; a new event beats the ack
  always @(posedge clk_i) begin
    if (srst) begin
      idg_q         <= 1'b1;
      rx_alt_q      <= 1'b0;
      rx_id_q       <= 1'b0;
      rxcmd_valid_o <= 1'b0;
      rxcmd_o       <= 8'h00;
    end else begin
      idg_q <= id_grounded_comparator_i;
      if (rxcmd_ack_i) begin
        rx_alt_q <= 1'b0;
        rx_id_q  <= 1'b0;
      end
      if (state_q == ST_SYNC && idg_q && !id_grounded_comparator_i) begin
        rx_id_q <= 1'b1;
      end
      if (id_done && id_measure_irq_enable_q) begin
        rx_alt_q <= 1'b1;
      end
      rxcmd_valid_o <= (rx_alt_q | rx_id_q) & ~rxcmd_ack_i & state_q == ST_SYNC;
      rxcmd_o       <= 8'h00;
      rxcmd_o[`UAM_RX_ID]  <= id_grounded_comparator_i;
      rxcmd_o[`UAM_RX_ALT] <= rx_alt_q;
    end
  end
endmodule // uam_alt_mux

// ===== hw/uam_id_measure.v
// id resistance converter sequencer
`timescale 1ns/1ps
`include "uam_regs.vh"
module uam_id_measure #(
  parameter W    = 4,
  parameter CONV = `UAM_CONV_CYC
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         start_i,
  input  wire [W-1:0] code_i,
  output wire         busy_o,
  output reg          done_o,
  output reg  [W-1:0] result_o
);
  reg        busy_q;
  reg [15:0] cnt_q;
  // =====================================================================
  // conversion timer
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_q   <= 1'b0;
      cnt_q    <= 16'h0000;
      done_o   <= 1'b0;
      result_o <= {W{1'b0}};
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= CONV[15:0] - 16'h0001;
      end else if (busy_q) begin
        if (cnt_q == 16'h0000) begin
          busy_q   <= 1'b0;
          done_o   <= 1'b1;
          result_o <= code_i;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end
  assign busy_o = busy_q;
endmodule // uam_id_measure

// ===== hw/uam_irq_sampler.v
// interrupt baseline sampler for the alternate modes
`timescale 1ns/1ps
module uam_irq_sampler #(
  parameter N = 8
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         sample_i,
  input  wire [N-1:0] src_i,
  input  wire [N-1:0] mask_i,
  output wire         irq_o
);
  reg [N-1:0] base_q;
  // =====================================================================
  // baseline latch
  always @(posedge clk_i) begin
    if (rst_i) begin
      base_q <= {N{1'b0}};
    end else if (sample_i) begin
      base_q <= src_i;
    end
  end
  // level compare, so a change that returns clears the request again
  assign irq_o = |((src_i ^ base_q) & mask_i);
endmodule // uam_irq_sampler

// ===== hw/uam_regs.vh
// constants of the ulpi alternate-mode mux: offsets, fields, reset values
`ifndef UAM_REGS_VH
`define UAM_REGS_VH
// =====================================================================
// register byte offsets
`define UAM_ADR_IFC    5'h00
`define UAM_ADR_FUNC   5'h04
`define UAM_ADR_CARKIT 5'h08
`define UAM_ADR_HSET   5'h0c
`define UAM_ADR_IDCONV 5'h10
`define UAM_ADR_IOPWR  5'h14
`define UAM_ADR_MASK   5'h18
`define UAM_ADR_STAT   5'h1c
// =====================================================================
// field positions
`define UAM_IFC_SER6   0
`define UAM_IFC_CAR    2
`define UAM_IFC_KEEP   3
`define UAM_CK_TXEN    0
`define UAM_CK_RXEN    1
`define UAM_CK_LEFT    2
`define UAM_CK_RIGHT   3
`define UAM_ID_START   0
`define UAM_ID_IRQEN   1
`define UAM_ID_RES_LSB 4
`define UAM_RX_ID      6
`define UAM_RX_ALT     7
`define UAM_SRC_VBUS   0
// =====================================================================
// reset values and encodings
`define UAM_FUNC_RST   2'h1
`define UAM_MASK_RST   8'h00
`define UAM_XS_HS      2'h0
`define UAM_XS_FS      2'h1
`define UAM_XS_LS      2'h2
`define UAM_XS_FSPRE   2'h3
`define UAM_CONV_CYC   16
`endif
